/* File: bws_defines.svh */
`ifndef BWS_DEFINES_SVH
`define BWS_DEFINES_SVH

// timebase
`define BWS_CLK_NS        40
`define BWS_CEIL(ns)      (((ns) + `BWS_CLK_NS - 1) / `BWS_CLK_NS)
`define BWS_FLOOR(ns)     ((ns) / `BWS_CLK_NS)

// sequence and power-stage times in ns
`define BWS_WAKE_NS       2200
`define BWS_ZC_WIN_NS     2200
`define BWS_BLANK_LO_NS   110
`define BWS_BLANK_HI_NS   190
`define BWS_MINON_LO_NS   110
`define BWS_MINON_HI_NS   100
`define BWS_FAULT_NS      2000

// derived cycle counts
`define BWS_WAKE_CYC      `BWS_CEIL(`BWS_WAKE_NS)
`define BWS_ZC_WIN_CYC    `BWS_FLOOR(`BWS_ZC_WIN_NS)
`define BWS_BLANK_LO_CYC  `BWS_CEIL(`BWS_BLANK_LO_NS)
`define BWS_BLANK_HI_CYC  `BWS_CEIL(`BWS_BLANK_HI_NS)
`define BWS_MINON_LO_CYC  `BWS_CEIL(`BWS_MINON_LO_NS)
`define BWS_MINON_HI_CYC  `BWS_CEIL(`BWS_MINON_HI_NS)
`define BWS_FAULT_CYC     `BWS_FLOOR(`BWS_FAULT_NS)

// register offsets (byte addresses)
`define BWS_OFF_CTRL      12'h000
`define BWS_OFF_STATUS    12'h004
`define BWS_OFF_INT_STAT  12'h008
`define BWS_OFF_INT_MASK  12'h00c
`define BWS_OFF_CONFIG    12'h010

// fields
`define BWS_CTRL_EN       0
`define BWS_CTRL_LPM      1
`define BWS_EV_START      0
`define BWS_EV_FAULT      1
`define BWS_EV_ZC_TO      2
`define BWS_EV_W          3

// reset values
`define BWS_CTRL_RST      2'h0
`define BWS_MASK_RST      3'h0

`endif

/* File: bws_pkg.sv */
package bws_pkg;
  typedef enum logic [1:0] {
    bws_st_idle,
    bws_st_wake,
    bws_st_zc,
    bws_st_run
  } bws_state_t;
endpackage : bws_pkg

/* File: bws_sync.sv */
`timescale 1ns/100ps
module bws_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta[i]     <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta[i]     <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule : bws_sync

/* File: bws_timer.sv */
`timescale 1ns/100ps
module bws_timer #(
  parameter int unsigned W     = 8,
  parameter logic [W-1:0] LIMIT = 8'h37
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clr,
  input  wire logic en,
  output logic      done
);
  logic [W-1:0] cnt;

  // saturates at the limit so done stays up until cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (clr) begin
      cnt <= '0;
    end else if (en && !done) begin
      cnt <= cnt + 1'b1;
    end
  end

  assign done = (cnt == LIMIT);
endmodule : bws_timer

/* File: bws_wake_seq.sv */
// Operation
// - gates switch only while run is high
// - run low during every burst off-time
// - wake-up delay 2.2 us before first pulse
// - first pulse waits for bias power-good
// - zero-cross window 2.2 us, timeout fires pulse
// - wake delay and power-good run in parallel
// - strap selects zero-voltage target 4/8.5 V
// - strap selects blanking 110/190 ns
// - low-power minimum on-time 110/100 ns
// - on-time reaching 2 us flags sense fault
// - switched bias follows run output
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "bws_defines.svh"
module bws_wake_seq
  import bws_pkg::*;
#(
  parameter logic [7:0] FAULT_RDM_HI_CYC = 8'h32
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        burst_active,
  input  wire logic        pwm_low_req,
  input  wire logic        pwm_high_req,
  input  wire logic        bias_good_pin,
  input  wire logic        zero_cross_detect,
  input  wire logic        strap_pin,
  input  wire logic        demag_below_th_pin,
  output logic             run_out,
  output logic             switched_bias_out,
  output logic             low_side_gate_out,
  output logic             sync_rect_gate_out,
  output logic             zero_voltage_target_hi,
  output logic             sense_blank_out,
  output logic             irq
);
  localparam logic [7:0] WAKE_CYC = 8'(`BWS_WAKE_CYC);
  localparam logic [7:0] ZC_CYC   = 8'(`BWS_ZC_WIN_CYC);
  localparam logic [7:0] FAULT_CYC = 8'(`BWS_FAULT_CYC);

  bws_state_t st;
  logic [1:0] ctrl;
  logic [`BWS_EV_W-1:0] int_stat;
  logic [`BWS_EV_W-1:0] int_mask;
  logic [`BWS_EV_W-1:0] events;
  logic [3:0] pins_s;
  logic bias_ok;
  logic zc_s;
  logic zc_d;
  logic zc_rise;
  logic strap_hi;
  logic demag_lo;
  logic next_run;
  logic wake_done;
  logic zc_done;
  logic fire;
  logic lg;
  logic sr;
  logic [7:0] on_cnt;
  logic [7:0] blank_cyc;
  logic [7:0] minon_cyc;
  logic [7:0] fault_cyc;
  logic fault_hit;
  logic min_met;
  logic lpm;

  // pins arrive from the analog side, two stages before use
  bws_sync #(.W(4)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({demag_below_th_pin, strap_pin, zero_cross_detect,
                bias_good_pin}),
    .sync_out (pins_s)
  );
  assign bias_ok  = pins_s[0];
  assign zc_s     = pins_s[1];
  assign strap_hi = pins_s[2];
  assign demag_lo = pins_s[3];
  assign lpm      = ctrl[`BWS_CTRL_LPM];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zc_d <= 1'b0;
    end else begin
      zc_d <= zc_s;
    end
  end
  assign zc_rise = zc_s && !zc_d;

  // strap-selected power-stage constants
  assign zero_voltage_target_hi = strap_hi;
  assign blank_cyc = strap_hi ? 8'(`BWS_BLANK_HI_CYC)
                              : 8'(`BWS_BLANK_LO_CYC);
  assign minon_cyc = strap_hi ? 8'(`BWS_MINON_HI_CYC)
                              : 8'(`BWS_MINON_LO_CYC);
  // strap low with a large demag resistor uses a separate limit
  assign fault_cyc = (strap_hi || demag_lo) ? FAULT_CYC
                                            : FAULT_RDM_HI_CYC;

  // run: burst off-time drops it, which also lets isolator bias decay
  assign next_run = ctrl[`BWS_CTRL_EN] && burst_active;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_out <= 1'b0;
    end else begin
      run_out <= next_run;
    end
  end
  assign switched_bias_out = run_out;

  bws_timer #(.W(8), .LIMIT(WAKE_CYC)) u_wake (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (st != bws_st_wake),
    .en      (st == bws_st_wake),
    .done    (wake_done)
  );

  bws_timer #(.W(8), .LIMIT(ZC_CYC)) u_zc (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (st != bws_st_zc),
    .en      (st == bws_st_zc),
    .done    (zc_done)
  );

  assign fire = (st == bws_st_zc) && (zc_rise || zc_done);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= bws_st_idle;
    end else if (!run_out) begin
      st <= bws_st_idle;
    end else begin
      unique case (st)
        bws_st_idle: st <= bws_st_wake;
        bws_st_wake: begin
          if (wake_done && bias_ok) begin
            st <= bws_st_zc;
          end
        end
        bws_st_zc: begin
          if (fire) begin
            st <= bws_st_run;
          end
        end
        bws_st_run: st <= bws_st_run;
      endcase
    end
  end

  assign fault_hit = lg && (on_cnt == fault_cyc - 8'h01);
  assign min_met   = !lpm || (on_cnt >= minon_cyc - 8'h01);

  // low-side gate; next_run clears it the same edge run falls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lg <= 1'b0;
    end else if (!next_run || !run_out) begin
      lg <= 1'b0;
    end else if (fire) begin
      lg <= 1'b1;
    end else if (fault_hit) begin
      lg <= 1'b0;
    end else if (lg && !pwm_low_req && min_met) begin
      lg <= 1'b0;
    end else if (!lg && st == bws_st_run && pwm_low_req
                 && !pwm_high_req) begin
      lg <= 1'b1;
    end
  end
  assign low_side_gate_out = lg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_cnt <= 8'h00;
    end else if (!lg) begin
      on_cnt <= 8'h00;
    end else if (on_cnt != 8'hff) begin
      on_cnt <= on_cnt + 8'h01;
    end
  end
  assign sense_blank_out = lg && (on_cnt < blank_cyc);

  // sync-rect gate never overlaps the low-side gate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr <= 1'b0;
    end else begin
      sr <= next_run && run_out && st == bws_st_run && pwm_high_req
            && !pwm_low_req && !lg;
    end
  end
  assign sync_rect_gate_out = sr;

  // events and interrupt
  assign events[`BWS_EV_START] = fire;
  assign events[`BWS_EV_FAULT] = fault_hit;
  assign events[`BWS_EV_ZC_TO] = (st == bws_st_zc) && zc_done && !zc_rise;

  logic wr;
  logic rd_setup;
  logic mapped;
  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign mapped = (paddr == `BWS_OFF_CTRL) || (paddr == `BWS_OFF_STATUS)
               || (paddr == `BWS_OFF_INT_STAT)
               || (paddr == `BWS_OFF_INT_MASK)
               || (paddr == `BWS_OFF_CONFIG);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `BWS_CTRL_RST;
    end else if (wr && paddr == `BWS_OFF_CTRL) begin
      ctrl <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask <= `BWS_MASK_RST;
    end else if (wr && paddr == `BWS_OFF_INT_MASK) begin
      int_mask <= pwdata[`BWS_EV_W-1:0];
    end
  end

  // write-one-to-clear; a same-cycle event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= '0;
    end else if (wr && paddr == `BWS_OFF_INT_STAT) begin
      int_stat <= (int_stat & ~pwdata[`BWS_EV_W-1:0]) | events;
    end else begin
      int_stat <= int_stat | events;
    end
  end
  assign irq = |(int_stat & int_mask);

  // read data captured in the setup phase, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr)
        `BWS_OFF_CTRL:     prdata <= {30'h0, ctrl};
        `BWS_OFF_STATUS:   prdata <= {25'h0, st, demag_lo, strap_hi,
                                      bias_ok, lg, run_out};
        `BWS_OFF_INT_STAT: prdata <= {29'h0, int_stat};
        `BWS_OFF_INT_MASK: prdata <= {29'h0, int_mask};
        `BWS_OFF_CONFIG:   prdata <= {blank_cyc, minon_cyc, fault_cyc,
                                      7'h0, strap_hi};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

  // helper: cycles since run rose, for the wake check
  logic [7:0] run_age;
  localparam int WAKE_I = `BWS_WAKE_CYC;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_age <= 8'h00;
    end else if (!run_out) begin
      run_age <= 8'h00;
    end else if (run_age != 8'hff) begin
      run_age <= run_age + 8'h01;
    end
  end

  gates_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !run_out |-> !low_side_gate_out && !sync_rect_gate_out)
    else $error("gate active while run low");

  run_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !burst_active |=> !run_out)
    else $error("run high during burst off-time");

  wake_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(low_side_gate_out) |-> run_age >= WAKE_I)
    else $error("first pulse before wake-up delay");

  bias_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st == bws_st_wake && !bias_ok) |=> st != bws_st_zc)
    else $error("window opened without power-good");

  zc_fire_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st == bws_st_zc && zc_rise && next_run && run_out)
      |=> low_side_gate_out)
    else $error("zero crossing did not fire pulse");

  zc_expire_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st == bws_st_zc) |-> ##[1:57] (low_side_gate_out || !run_out))
    else $error("window expiry did not fire pulse");

  both_gates_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st == bws_st_zc) |-> $past(wake_done) && $past(bias_ok))
    else $error("window opened before both delays");

  target_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
    zero_voltage_target_hi == $past(strap_pin, 2))
    else $error("zero-voltage target mismatch");

  blank_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(lg) && !strap_hi) ##0 (lg && !strap_hi)[*4] |->
      (!sense_blank_out && $past(sense_blank_out)
       && $past(sense_blank_out, 3)))
    else $error("blanking length wrong, strap low");

  blank_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(lg) && strap_hi) ##0 (lg && strap_hi)[*5] |->
      (sense_blank_out && $past(sense_blank_out, 4)) ##1 !sense_blank_out)
    else $error("blanking length wrong, strap high");

  min_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(lg) && $past(lpm) && $past(next_run) && $past(run_out))
      |-> $past(on_cnt) >= $past(minon_cyc) - 8'h01)
    else $error("minimum on-time violated");

  fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fault_hit && next_run && run_out) |=>
      !lg && int_stat[`BWS_EV_FAULT])
    else $error("sense fault not flagged");

  bias_sw_a: assert property (@(posedge pclk) disable iff (!presetn)
    switched_bias_out == run_out)
    else $error("switched bias not following run");

  restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(run_out) |=> st == bws_st_idle && !lg)
    else $error("sequence not abandoned on run drop");

  cv_zc_hit: cover property (@(posedge pclk) disable iff (!presetn)
    st == bws_st_zc && zc_rise);
  cv_zc_to: cover property (@(posedge pclk) disable iff (!presetn)
    events[`BWS_EV_ZC_TO]);
  cv_fault: cover property (@(posedge pclk) disable iff (!presetn)
    fault_hit);
  cv_abort: cover property (@(posedge pclk) disable iff (!presetn)
    st == bws_st_wake ##1 !run_out);
endmodule : bws_wake_seq

/* File: bws_far_model.sv */
`timescale 1ns/100ps
module bws_far_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       switched_bias_out,
  input  wire logic       run_out,
  input  wire logic       low_side_gate_out,
  input  wire logic       zc_on,
  input  wire logic [8:0] bias_dly,
  output logic            bias_good_pin,
  output logic            zero_cross_detect
);
  logic [8:0] chg;
  logic [2:0] ring;

  // bias cap drains at once when the switch opens: the harshest case
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg <= '0;
    end else if (!switched_bias_out) begin
      chg <= '0;
    end else if (chg != 9'h1ff) begin
      chg <= chg + 9'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ring <= '0;
    end else begin
      ring <= ring + 3'h1;
    end
  end

  assign bias_good_pin = switched_bias_out && (chg >= bias_dly);
  // aux winding rings only while awake and the primary switch is off
  assign zero_cross_detect = zc_on && run_out && !low_side_gate_out
                             && ring[2] && ring[1];
endmodule : bws_far_model

/* File: tb.sv */
`timescale 1ns/100ps
`include "bws_defines.svh"
module tb;
  localparam int WAKE = 2200 / 40;
  localparam int WIN = 2200 / 40;
  localparam int FLT = 2000 / 40;
  // large demag resistor: design default limit
  localparam int FLT_RDM = 2000 / 40;
  localparam int BLK_LO = (110 + 39) / 40;
  localparam int BLK_HI = (190 + 39) / 40;
  localparam int MON_LO = (110 + 39) / 40;
  localparam int MON_HI = (100 + 39) / 40;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic        pready, pslverr, e;
  logic        burst_active = 0, pwm_low_req = 0, pwm_high_req = 1;
  logic        strap_pin = 0, demag_below_th_pin = 1, zc_on = 1;
  logic [8:0]  bias_dly = '0;
  logic        bias_good_pin, zero_cross_detect, run_out, switched_bias_out;
  logic        low_side_gate_out, sync_rect_gate_out, irq;
  logic        zero_voltage_target_hi, sense_blank_out;
  int          fails = 0, num_checks = 0, cyc = 0, t, b, n;

  always #20 pclk = ~pclk;

  bws_wake_seq i_bws_wake_seq (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .burst_active(burst_active), .pwm_low_req(pwm_low_req),
    .pwm_high_req(pwm_high_req), .bias_good_pin(bias_good_pin),
    .zero_cross_detect(zero_cross_detect), .strap_pin(strap_pin),
    .demag_below_th_pin(demag_below_th_pin), .run_out(run_out),
    .switched_bias_out(switched_bias_out),
    .low_side_gate_out(low_side_gate_out),
    .sync_rect_gate_out(sync_rect_gate_out),
    .zero_voltage_target_hi(zero_voltage_target_hi),
    .sense_blank_out(sense_blank_out), .irq(irq));

  bws_far_model i_bws_far_model (.pclk(pclk), .presetn(presetn),
    .switched_bias_out(switched_bias_out), .run_out(run_out),
    .low_side_gate_out(low_side_gate_out), .zc_on(zc_on),
    .bias_dly(bias_dly), .bias_good_pin(bias_good_pin),
    .zero_cross_detect(zero_cross_detect));

  task conclude;
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // hangs are cut here rather than in every wait loop
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      conclude;
    end
  end

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task burst_on;
    @(posedge pclk) burst_active <= 1;
    repeat (2) @(negedge pclk);
    chk("run", 1, run_out);
    chk("bias sw", 1, switched_bias_out);
  endtask : burst_on

  task first_delay;
    burst_on;
    t = 0;
    while (low_side_gate_out !== 1'b1 && t < 400) begin
      @(negedge pclk);
      t++;
    end
  endtask : first_delay

  task stop_burst;
    @(posedge pclk);
    burst_active <= 0;
    pwm_low_req <= 0;
    pwm_high_req <= 1;
    repeat (2) @(negedge pclk);
    chk("run off", 0, run_out);
    chk("bias sw off", 0, switched_bias_out);
    chk("gates off", 0, {low_side_gate_out, sync_rect_gate_out});
    repeat (4) @(negedge pclk);
    chk("sr held", 0, sync_rect_gate_out);
  endtask : stop_burst

  task t_regs;
    apb(0, `BWS_OFF_CTRL, 0);
    chk("ctrl rst", 0, r);
    apb(0, `BWS_OFF_INT_MASK, 0);
    chk("mask rst", 0, r);
    apb(1, 12'h020, 32'hffffffff);
    chk("unmapped wr", 1, e);
    apb(0, 12'h020, 0);
    chk("unmapped rd", 0, r);
    chk("unmapped rd err", 1, e);
    apb(1, `BWS_OFF_CTRL, 32'h1);
  endtask : t_regs

  task t_quick;
    apb(1, `BWS_OFF_INT_MASK, 32'h1);
    first_delay;
    chk("wake+zc", 1, t >= WAKE && t <= WAKE + 16);
    apb(0, `BWS_OFF_INT_STAT, 0);
    chk("first evt", 1, r[0]);
    chk("irq set", 1, irq);
    apb(1, `BWS_OFF_INT_STAT, 32'h7);
    @(negedge pclk);
    chk("irq clr", 0, irq);
    chk("sr on", 1, sync_rect_gate_out);
    @(posedge pclk);
    pwm_high_req <= 0;
    pwm_low_req <= 1;
    repeat (2) @(negedge pclk);
    chk("lg on req", 1, low_side_gate_out);
    chk("sr off", 0, sync_rect_gate_out);
    stop_burst;
  endtask : t_quick

  task t_bias_late;
    bias_dly = 9'd150;
    first_delay;
    chk("bias wait", 1, t >= 150 && t <= 170);
    stop_burst;
    bias_dly = '0;
  endtask : t_bias_late

  task t_timeout;
    zc_on = 0;
    first_delay;
    chk("zc window", 1, t >= WAKE + WIN && t <= WAKE + WIN + 6);
    apb(0, `BWS_OFF_INT_STAT, 0);
    chk("zc to evt", 1, r[2]);
    apb(1, `BWS_OFF_INT_STAT, 32'h7);
    stop_burst;
    zc_on = 1;
  endtask : t_timeout

  task t_abandon;
    burst_on;
    repeat (30) @(negedge pclk);
    stop_burst;
    first_delay;
    chk("restart", 1, t >= WAKE && t <= WAKE + 16);
    stop_burst;
  endtask : t_abandon

  task t_stage(input logic s, input logic dm, input logic lpm, input int eb,
               input int lo, input int hi);
    @(posedge pclk);
    strap_pin <= s;
    demag_below_th_pin <= dm;
    pwm_low_req <= !lpm;
    apb(1, `BWS_OFF_CTRL, {30'h0, lpm, 1'b1});
    repeat (4) @(negedge pclk);
    chk("zv target", s, zero_voltage_target_hi);
    first_delay;
    b = 0;
    n = 0;
    while (low_side_gate_out === 1'b1 && n < 200) begin
      b += (sense_blank_out === 1'b1);
      n++;
      @(negedge pclk);
    end
    chk("blank", eb, b);
    chk("on time", 1, n >= lo && n <= hi);
    apb(0, `BWS_OFF_INT_STAT, 0);
    chk("fault evt", !lpm, r[1]);
    apb(1, `BWS_OFF_INT_STAT, 32'h7);
    stop_burst;
  endtask : t_stage

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    t_regs;
    t_quick;
    t_bias_late;
    t_timeout;
    t_abandon;
    t_stage(1, 0, 0, BLK_HI, FLT, FLT + 1);
    t_stage(0, 1, 0, BLK_LO, FLT, FLT + 1);
    t_stage(0, 0, 0, BLK_LO, FLT_RDM, FLT_RDM + 1);
    // lpm pulses end at min-on, before blanking could run out
    t_stage(0, 0, 1, MON_LO, MON_LO, MON_LO + 1);
    t_stage(1, 0, 1, MON_HI, MON_HI, MON_HI + 1);
    conclude;
  end
endmodule : tb
